// *** verilog/reset_supervisor.sv ***
// Supervisor end: undervoltage, manual reset and watchdog reset generator
// What this block does
// RULE1: Undervoltage asserts reset, stretched by timeout
// RULE2: Manual reset low holds reset, then timeout
// RULE3: Undervoltage drives both reset outputs; OUT_ACTIVE_HIGH leaves the active-low output undriven
// RULE4: Unconnected manual reset reads as released
// RULE5: Manual reset input is glitch filtered
// RULE6: No kick edge in timeout causes reset
// RULE7: Kick edge or reset clears watchdog
// RULE8: Short kick pulses count as toggles
// RULE9: Watchdog held at zero during reset
// RULE10: Watchdog counts from zero after release
// RULE11: Undriven kick input disables watchdog
// RULE12: Self-kick low seven eighths, high last eighth
// RULE13: Processor pulses kick early, low mostly
// RULE14: Open-drain reset lets either party pull
// RULE15: Software toggles kick at separate places
// RULE16: Build options choose output and functions
// RULE17: Undervoltage and undriven flags are synchronous
`timescale 1ns/1ps
module reset_supervisor #(
    parameter supervisor_pkg::out_style_t OUT_STYLE =
        supervisor_pkg::OUT_ACTIVE_LOW,
    parameter bit HAS_WATCHDOG = 1'b1,
    parameter bit HAS_MANUAL = 1'b1,
    parameter logic [31:0] RESET_CYC =
        32'(supervisor_pkg::RESET_TIMEOUT_CYC),
    parameter logic [31:0] WD_CYC =
        32'(supervisor_pkg::WD_TIMEOUT_CYC)
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic       undervolt,
    input  wire logic       kick_undriven,
    input  wire logic       manual_reset_n,
    input  wire logic       manual_reset_n_valid,
    output logic            reset_active,
    supervisor_if.dev       link
);
    logic [1:0]              mr_sync_r;
    logic [1:0]              kick_sync_r;
    logic                    kick_prev_r;
    logic [supervisor_pkg::FLT_W-1:0] mr_flt_r;
    logic                    mr_low_r;
    logic [31:0]             wd_cnt_r;
    logic [31:0]             rto_cnt_r;
    logic                    self_kick_r;
    logic                    wd_expire_r;
    logic                    rst_r;
    logic                    rst_n_out_r;
    logic                    rst_n_oe_r;
    logic                    rst_hi_r;
    supervisor_pkg::sup_state_t state_r;
    supervisor_pkg::sup_state_t state_nxt;
    logic                    mr_raw;
    logic                    kick_seen;
    logic                    kick_edge;
    logic                    cause;

    // Open or unconnected manual input reads as high (pull-up)
    assign mr_raw = manual_reset_n_valid ? manual_reset_n : 1'b1; // RULE4
    // Undriven kick pin follows the internal weak driver
    assign kick_seen = kick_undriven ? self_kick_r          // RULE11
                                     : link.kick_line;

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mr_sync_r   <= 2'h3;
            kick_sync_r <= 2'h0;
            kick_prev_r <= supervisor_pkg::KICK_INIT;
        end else if (clk_en) begin
            mr_sync_r   <= {mr_sync_r[0], mr_raw};
            kick_sync_r <= {kick_sync_r[0], kick_seen};
            kick_prev_r <= kick_sync_r[1];
        end
    end

    // Every sampled level change is one toggle; 50 ns is one clock
    assign kick_edge = kick_sync_r[1] ^ kick_prev_r; // RULE8

    // Glitch filter: level must hold for the filter time to count
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mr_flt_r <= '0;
            mr_low_r <= 1'b0;
        end else if (clk_en) begin
            if (mr_sync_r[1] == mr_low_r) begin // RULE5
                if (mr_flt_r >= supervisor_pkg::FLT_W'(
                        supervisor_pkg::MR_FILTER_CYC)) begin
                    mr_low_r <= !mr_sync_r[1];
                    mr_flt_r <= '0;
                end else begin
                    mr_flt_r <= mr_flt_r + 1'b1;
                end
            end else begin
                mr_flt_r <= '0;
            end
        end
    end

    // Combined reset cause from all enabled sources
    assign cause = undervolt                       // RULE1 RULE17
                 || (HAS_MANUAL && mr_low_r)       // RULE2
                 || (HAS_WATCHDOG && wd_expire_r); // RULE6

    // Reset sequencer: hold while cause, stretch, then run
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            supervisor_pkg::ST_HOLD: begin
                if (!cause)
                    state_nxt = supervisor_pkg::ST_STRETCH;
            end
            supervisor_pkg::ST_STRETCH: begin
                if (cause)
                    state_nxt = supervisor_pkg::ST_HOLD;
                else if (rto_cnt_r >= RESET_CYC - 32'h1)
                    state_nxt = supervisor_pkg::ST_RUN;
            end
            supervisor_pkg::ST_RUN: begin
                if (cause)
                    state_nxt = supervisor_pkg::ST_HOLD;
            end
            default: state_nxt = supervisor_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= supervisor_pkg::ST_HOLD;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // Reset timeout counter, restarted whenever a cause appears
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rto_cnt_r <= '0;
        end else if (clk_en) begin
            if (state_r == supervisor_pkg::ST_STRETCH && !cause)
                rto_cnt_r <= rto_cnt_r + 32'h1; // RULE1 RULE2
            else
                rto_cnt_r <= '0;
        end
    end

    // Internal reset state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_r <= supervisor_pkg::RST_ASSERTED_INIT;
        end else if (clk_en) begin
            rst_r <= (state_nxt != supervisor_pkg::ST_RUN);
        end
    end

    // Watchdog counter: cleared by reset or kick edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wd_cnt_r    <= '0;
            wd_expire_r <= 1'b0;
        end else if (clk_en) begin
            if (rst_r || !HAS_WATCHDOG) begin
                wd_cnt_r    <= '0; // RULE9
                wd_expire_r <= 1'b0;
            end else if (kick_edge) begin
                wd_cnt_r    <= '0; // RULE7
                wd_expire_r <= 1'b0;
            end else if (wd_cnt_r >= WD_CYC - 32'h1) begin
                wd_expire_r <= 1'b1; // RULE6
            end else begin
                wd_cnt_r <= wd_cnt_r + 32'h1; // RULE10
            end
        end
    end

    // Internal weak driver: high during the last eighth of the period
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            self_kick_r <= supervisor_pkg::KICK_INIT;
        end else if (clk_en) begin
            self_kick_r <= (64'(wd_cnt_r) * supervisor_pkg::SELF_KICK_DEN
                >= 64'(WD_CYC) * supervisor_pkg::SELF_KICK_NUM); // RULE12
        end
    end

    // Registered pin outputs in the chosen style
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_n_out_r <= 1'b0;
            rst_n_oe_r  <= 1'b1;
            rst_hi_r    <= 1'b1;
        end else if (clk_en) begin
            // Active-high output mirrors every reset request in all styles
            rst_hi_r    <= (state_nxt != supervisor_pkg::ST_RUN); // RULE3
            rst_n_out_r <= (OUT_STYLE == supervisor_pkg::OUT_OPEN_DRAIN)
                           ? 1'b0
                           : (state_nxt == supervisor_pkg::ST_RUN);
            rst_n_oe_r  <= (OUT_STYLE == supervisor_pkg::OUT_OPEN_DRAIN)
                           ? (state_nxt != supervisor_pkg::ST_RUN) // RULE14
                           : (OUT_STYLE == supervisor_pkg::OUT_ACTIVE_LOW);
        end
    end

    assign link.reset_n_o  = rst_n_out_r;
    assign link.reset_n_oe = rst_n_oe_r;
    assign link.reset_hi_o = rst_hi_r;
    assign reset_active    = rst_r;
endmodule : reset_supervisor

// *** verilog/supervisor_pkg.sv ***
// Shared constants and types for the reset supervisor and its processor end
package supervisor_pkg;
    // Clock period of the supervisor oscillator in nanoseconds
    localparam int unsigned CLK_PERIOD_NS = 50;
    // Reset timeout period, least figure, in milliseconds
    localparam int unsigned RESET_TIMEOUT_MS = 140;
    localparam int unsigned RESET_TIMEOUT_CYC =
        (RESET_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Nominal watchdog timeout in milliseconds
    localparam int unsigned WD_TIMEOUT_MS = 1600;
    localparam longint unsigned WD_TIMEOUT_CYC =
        (64'(WD_TIMEOUT_MS) * 64'd1000000) / CLK_PERIOD_NS;
    // Least kick pulse width in nanoseconds
    localparam int unsigned KICK_PULSE_NS = 50;
    localparam int unsigned KICK_PULSE_CYC =
        (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Manual reset glitch filter time in nanoseconds
    localparam int unsigned MR_FILTER_NS = 100;
    localparam int unsigned MR_FILTER_CYC =
        (MR_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Self-kick goes high after seven eighths of the watchdog period
    localparam int unsigned SELF_KICK_NUM = 7;
    localparam int unsigned SELF_KICK_DEN = 8;
    // Counter widths
    localparam int unsigned TMO_W = 32;
    localparam int unsigned FLT_W = 4;
    // Reset values
    localparam logic RST_ASSERTED_INIT = 1'b1;
    localparam logic KICK_INIT = 1'b0;

    // Reset output style
    typedef enum logic [1:0] {
        OUT_ACTIVE_LOW  = 2'h0,
        OUT_ACTIVE_HIGH = 2'h1,
        OUT_OPEN_DRAIN  = 2'h2
    } out_style_t;

    // Supervisor reset sequencer
    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_STRETCH = 2'h1,
        ST_RUN = 2'h2
    } sup_state_t;
endpackage : supervisor_pkg

// *** verilog/supervisor_if.sv ***
// Wires between the supervisor and the processor end
`timescale 1ns/1ps
interface supervisor_if;
    logic kick_o;
    logic kick_oe;
    logic reset_n_o;
    logic reset_n_oe;
    logic reset_hi_o;
    logic cpu_reset_o;
    logic cpu_reset_oe;
    logic reset_line;
    logic kick_line;

    // Wired level of the open-drain reset line and the kick line
    assign reset_line = !((reset_n_oe && !reset_n_o) ||
                          (cpu_reset_oe && !cpu_reset_o));
    assign kick_line = kick_oe ? kick_o : 1'b0;

    modport dev (
        output reset_n_o,
        output reset_n_oe,
        output reset_hi_o,
        input  kick_line,
        input  kick_oe,
        input  reset_line
    );
    modport cpu (
        output kick_o,
        output kick_oe,
        output cpu_reset_o,
        output cpu_reset_oe,
        input  reset_line,
        input  reset_hi_o
    );
endinterface : supervisor_if

// *** verilog/cpu_kick_end.sv ***
// Processor end: drives the watchdog kick and shares the reset line
`timescale 1ns/1ps
module cpu_kick_end (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic clk_en,
    input  wire logic kick_enable,
    input  wire logic kick_set,
    input  wire logic kick_clear,
    input  wire logic assert_reset,
    output logic      in_reset,
    supervisor_if.cpu link
);
    logic [1:0] rst_sync_r;
    logic       kick_r;
    logic       kick_oe_r;
    logic       cpu_rst_oe_r;
    logic       in_reset_r;

    // Reset line synchronised before use
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_r <= 2'h0;
            in_reset_r <= 1'b1;
        end else if (clk_en) begin
            rst_sync_r <= {rst_sync_r[0], link.reset_line};
            in_reset_r <= !rst_sync_r[1];
        end
    end

    // Kick set and cleared at separate program points; undriven if off
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kick_r    <= 1'b0;
            kick_oe_r <= 1'b0;
        end else if (clk_en) begin
            kick_oe_r <= kick_enable; // RULE11
            if (kick_set)
                kick_r <= 1'b1; // RULE15
            else if (kick_clear)
                kick_r <= 1'b0; // RULE13
        end
    end

    // Processor may pull the shared reset line low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_rst_oe_r <= 1'b0;
        end else if (clk_en) begin
            cpu_rst_oe_r <= assert_reset; // RULE14
        end
    end

    assign link.kick_o       = kick_r;
    assign link.kick_oe      = kick_oe_r;
    assign link.cpu_reset_o  = 1'b0;
    assign link.cpu_reset_oe = cpu_rst_oe_r;
    assign in_reset          = in_reset_r;
endmodule : cpu_kick_end

// *** sim/supervisor_monitor.sv ***
// Assertion checker watching the supervisor link wires
`timescale 1ns/1ps
module supervisor_monitor #(
    parameter logic [31:0] RESET_CYC = 32'h14,
    parameter logic [31:0] WD_CYC    = 32'h40
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic kick_oe,
    input wire logic kick_line,
    input wire logic reset_n_o,
    input wire logic reset_n_oe,
    input wire logic reset_hi_o,
    input wire logic cpu_reset_o,
    input wire logic cpu_reset_oe,
    input wire logic reset_line
);
    logic [31:0] low_cnt_r;
    logic [31:0] idle_cnt_r;
    logic        kick_q_r;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Length of the current low pulse on the supervisor output
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_r <= 32'h0;
        end else if (reset_n_o) begin
            low_cnt_r <= 32'h0;
        end else begin
            low_cnt_r <= low_cnt_r + 32'h1;
        end
    end

    // Cycles since the last kick edge while the line runs free
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            kick_q_r   <= 1'b0;
            idle_cnt_r <= 32'h0;
        end else begin
            kick_q_r <= kick_line;
            if (!reset_n_o || !kick_oe || kick_line != kick_q_r) begin
                idle_cnt_r <= 32'h0;
            end else begin
                idle_cnt_r <= idle_cnt_r + 32'h1;
            end
        end
    end

    chk_stretch_len: assert property (
        $rose(reset_n_o) |-> low_cnt_r >= RESET_CYC - 32'h1)
        else $error("reset released before the stretch ended");
    chk_pulse_min: assert property (
        $fell(reset_n_o) |-> !reset_n_o [*8])
        else $error("reset pulse too short");
    chk_wd_bound: assert property (
        idle_cnt_r <= WD_CYC + 32'h6)
        else $error("watchdog failed to expire");
    chk_start_state: assert property (
        $rose(nrst) |-> !reset_n_o && reset_hi_o && !kick_oe && !cpu_reset_oe)
        else $error("outputs wrong at reset release");
    chk_oe_steady: assert property (
        reset_n_oe)
        else $error("push-pull reset output not driven");
    chk_line_low: assert property (
        !reset_n_o |-> !reset_line)
        else $error("supervisor reset not on the line");
    chk_cpu_pull: assert property (
        cpu_reset_oe && !cpu_reset_o |-> !reset_line)
        else $error("processor pull not on the line");
    chk_kick_float: assert property (
        !kick_oe |-> !kick_line)
        else $error("undriven kick line not low");

    cov_wd_expire: cover property (idle_cnt_r == WD_CYC);
    cov_release: cover property ($rose(reset_n_o));
    cov_cpu_pull: cover property (cpu_reset_oe && !cpu_reset_o);
endmodule : supervisor_monitor

// *** sim/watchdog_supervisor_reset_tb.sv ***
// Self-checking bench joining the supervisor and processor ends
`timescale 1ns/1ps
module watchdog_supervisor_reset_tb;
    localparam int R = 32'h14;
    localparam int W = 32'h40;
    typedef struct {
        logic uv;
        logic mr;
        logic mv;
        int   hold;
        logic rst;
        int   slack;
    } row_t;
    logic clk, nrst, clk_en, undervolt, kick_undriven, seen;
    logic manual_reset_n, manual_reset_n_valid, reset_active;
    logic kick_enable, kick_set, kick_clear, assert_reset, in_reset;
    int   error_cnt, checked, cycles, n;
    // Cause, hold time, reset expected, release slack
    row_t rows [6] = '{
        '{1'b1, 1'b1, 1'b1, 8, 1'b1, 5},
        '{1'b1, 1'b1, 1'b1, 1, 1'b1, 5},
        '{1'b0, 1'b0, 1'b1, 12, 1'b1, 10},
        '{1'b0, 1'b0, 1'b1, 1, 1'b0, 0},
        '{1'b0, 1'b0, 1'b0, 12, 1'b0, 0},
        '{1'b1, 1'b0, 1'b1, 12, 1'b1, 10}
    };

    supervisor_if link();
    reset_supervisor #(.RESET_CYC(32'(R)), .WD_CYC(32'(W))) i_reset_supervisor (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .undervolt(undervolt),
        .kick_undriven(kick_undriven), .manual_reset_n(manual_reset_n),
        .manual_reset_n_valid(manual_reset_n_valid),
        .reset_active(reset_active), .link(link));
    cpu_kick_end i_cpu_kick_end (
        .clk(clk), .nrst(nrst), .clk_en(clk_en), .kick_enable(kick_enable),
        .kick_set(kick_set), .kick_clear(kick_clear),
        .assert_reset(assert_reset), .in_reset(in_reset), .link(link));
    supervisor_monitor #(.RESET_CYC(32'(R)), .WD_CYC(32'(W))) i_monitor (
        .clk(clk), .nrst(nrst), .kick_oe(link.kick_oe),
        .kick_line(link.kick_line), .reset_n_o(link.reset_n_o),
        .reset_n_oe(link.reset_n_oe), .reset_hi_o(link.reset_hi_o),
        .cpu_reset_o(link.cpu_reset_o), .cpu_reset_oe(link.cpu_reset_oe),
        .reset_line(link.reset_line));

    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 32'h4e20) begin
            error_cnt++;
            $display("mismatch at %0t: run timed out", $time);
            complete_run();
        end
    end
    // Sticky record of any supervisor reset
    always @(negedge clk) begin
        if (reset_active === 1'b1) seen = 1'b1;
    end

    task automatic chk(input logic ok, input string msg);
        checked++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %0s", $time, msg);
        end
    endtask : chk
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // Cycles until reset_active reaches the wanted level
    task automatic meas(input logic lvl, input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (reset_active !== lvl && n < lim);
    endtask : meas
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : complete_run

    initial begin
        nrst = 1'b0;
        clk_en = 1'b1;
        undervolt = 1'b0;
        kick_undriven = 1'b1;
        manual_reset_n = 1'b1;
        manual_reset_n_valid = 1'b1;
        kick_enable = 1'b0;
        kick_set = 1'b0;
        kick_clear = 1'b0;
        assert_reset = 1'b0;
        seen = 1'b0;
        error_cnt = 0;
        checked = 0;
        cycles = 0;
        cyc(8);
        nrst <= 1'b1;
        @(negedge clk);
        chk(reset_active === 1'b1 && in_reset === 1'b1, "reset state");
        chk(link.reset_line === 1'b0 && link.kick_oe === 1'b0, "pins");
        meas(1'b0, 200);
        chk(n >= R && n <= R + 6, "power-on stretch");
        $display("test reset done");
        foreach (rows[i]) begin
            cyc(1);
            seen = 1'b0;
            undervolt <= rows[i].uv;
            manual_reset_n <= rows[i].mr;
            manual_reset_n_valid <= rows[i].mv;
            cyc(rows[i].hold);
            if (rows[i].hold > 5 && rows[i].rst) begin
                @(negedge clk);
                chk(reset_active === 1'b1 && in_reset === 1'b1, "held");
                chk(link.reset_hi_o === 1'b1, "high output held");
                cyc(1);
            end
            undervolt <= 1'b0;
            manual_reset_n <= 1'b1;
            manual_reset_n_valid <= 1'b1;
            meas(1'b0, 200);
            if (!rows[i].rst) cyc(12);
            chk(seen === rows[i].rst, "reset seen");
            if (rows[i].rst) chk(n >= R && n <= R + rows[i].slack, "row");
            chk(link.reset_hi_o === 1'b0, "high output released");
        end
        $display("test table done");
        cyc(1);
        kick_undriven <= 1'b0;
        kick_enable <= 1'b1;
        undervolt <= 1'b1;
        cyc(3 * W);
        undervolt <= 1'b0;
        meas(1'b0, 200);
        meas(1'b1, 2 * W);
        chk(n >= W - 1 && n <= W + 6, "expiry after reset");
        meas(1'b0, 200);
        chk(n >= R && n <= R + 4, "expiry stretch");
        repeat (8) begin
            cyc(W / 2);
            kick_set <= 1'b1;
            cyc(1);
            kick_set <= 1'b0;
            kick_clear <= 1'b1;
            cyc(1);
            kick_clear <= 1'b0;
            @(negedge clk);
            chk(reset_active === 1'b0, "kicked watchdog");
        end
        meas(1'b1, 2 * W);
        chk(n >= W - 2 && n <= W + 8, "expiry after kicks");
        meas(1'b0, 200);
        cyc(1);
        seen = 1'b0;
        kick_enable <= 1'b0;
        kick_undriven <= 1'b1;
        cyc(4 * W);
        chk(seen === 1'b0, "self kick keeps quiet");
        $display("test watchdog done");
        assert_reset <= 1'b1;
        cyc(5);
        @(negedge clk);
        chk(link.reset_line === 1'b0 && in_reset === 1'b1, "cpu pull");
        cyc(1);
        assert_reset <= 1'b0;
        cyc(5);
        @(negedge clk);
        chk(in_reset === 1'b0, "line released");
        $display("test line done");
        // Clock enable low freezes the stretch counter
        undervolt <= 1'b1;
        cyc(2);
        undervolt <= 1'b0;
        cyc(2);
        clk_en <= 1'b0;
        cyc(30);
        clk_en <= 1'b1;
        meas(1'b0, 200);
        chk(n >= R - 2 && n <= R + 2, "frozen stretch");
        $display("test enable done");
        complete_run();
    end
endmodule : watchdog_supervisor_reset_tb
